// ### verilog/watchdog_status_enable_ctrl.sv
// Purpose: watchdog control register: status flag, enable/refresh, protected write
// Assumes: i_instr_done pulses in the last cycle of every core instruction;
//          at most one register write per instruction, at or before that pulse
// Notes:   i_reset_n is the external hardware reset; watchdog reset goes out only
//
// Overview of operation
// R01: watchdog interrupt always fixed high priority
// R02: unsupervised watchdog works as prescaled interrupt timer
// R03: timeout sets status flag at bit 2
// R04: status cleared by zero write or hardware reset
// R05: enable bit 1 starts and clears counter
// R06: missed refresh raises reset or interrupt
// R07: software writes via two-instruction protected sequence
// R08: only the next instruction's write is accepted
// R09: response select picks interrupt over reset
// R10: enable cleared by zero, reset, supply monitor
`timescale 1ns/1ps
module watchdog_status_enable_ctrl
  import watchdog_ctrl_pkg::*;
#(
  parameter int unsigned COUNT_W = 24,
  parameter int unsigned TICKS   = watchdog_ctrl_pkg::TICK_CYCLES
)(
  input  wire logic                               i_clk_sys,
  input  wire logic                               i_reset_n,
  input  wire logic                               i_sfr_wr,
  input  wire logic [watchdog_ctrl_pkg::REG_W-1:0] i_sfr_wdata,
  input  wire logic                               i_instr_done,
  input  wire logic                               i_supply_monitor_irq,
  output logic      [watchdog_ctrl_pkg::REG_W-1:0] o_sfr_rdata,
  output logic                                    o_wdt_reset,
  output logic                                    o_wdt_irq,
  output logic                                    o_wdt_irq_prio_high
);
  import watchdog_ctrl_pkg::*;

  localparam logic [COUNT_W-1:0] TICKS_W = COUNT_W'(TICKS);

  typedef struct packed {
    prot_state_t             prot;
    logic [PRESCALE_W-1:0]   prescale;
    logic                    irq_sel;
    logic                    status;
    logic                    enable;
    logic                    write_en;
    logic [COUNT_W-1:0]      count;
    logic                    wdt_reset;
    logic                    wdt_irq;
    logic                    prio_high;
    logic [REG_W-1:0]        rdata;
  } state_t;

  state_t st;
  state_t next_st;

  logic [PRESCALE_W-1:0] prescale_eff;
  logic [COUNT_W-1:0]    limit;
  logic                  timeout_hit;
  logic                  write_ok;
  logic                  arm_write;

  always_comb
  begin
    prescale_eff = (st.prescale > PRESCALE_MAX) ? PRESCALE_MAX : st.prescale;
    limit        = COUNT_W'((TICKS_W << prescale_eff) - COUNT_W'(1));
    timeout_hit  = st.enable && (st.count == limit);
    // a write only lands in the instruction right after arming
    write_ok     = i_sfr_wr && (st.prot == PROT_ARMED); // [R08]
    arm_write    = i_sfr_wr && !write_ok && i_sfr_wdata[BIT_WRITE_EN]; // [R07]
  end

  always_comb
  begin
    next_st           = st;
    next_st.wdt_reset = 1'b0;
    next_st.wdt_irq   = 1'b0;
    next_st.prio_high = 1'b1; // not software adjustable [R01]

    // protected write sequencer
    case (st.prot)
      PROT_IDLE:
      begin
        if (arm_write)
        begin
          next_st.write_en = 1'b1;
          next_st.prot     = i_instr_done ? PROT_ARMED : PROT_ARMING;
        end
      end
      PROT_ARMING:
      begin
        if (i_instr_done)
        begin
          next_st.prot = PROT_ARMED;
        end
      end
      PROT_ARMED:
      begin
        // any other instruction in between drops the permission
        if (write_ok || i_instr_done)
        begin
          next_st.prot     = PROT_IDLE;
          next_st.write_en = 1'b0;
        end
      end
      default:
      begin
        next_st.prot     = PROT_IDLE;
        next_st.write_en = 1'b0;
      end
    endcase

    // counter runs while enabled
    if (st.enable)
    begin
      next_st.count = timeout_hit ? '0 : COUNT_W'(st.count + COUNT_W'(1)); // [R02]
    end

    if (write_ok)
    begin
      next_st.prescale = i_sfr_wdata[BIT_PRESCALE_LO +: PRESCALE_W];
      next_st.irq_sel  = i_sfr_wdata[BIT_IRQ_SELECT];
      next_st.enable   = i_sfr_wdata[BIT_ENABLE]; // [R05] [R10]
      if (i_sfr_wdata[BIT_ENABLE])
      begin
        next_st.count = '0; // refresh [R05]
      end
      if (!i_sfr_wdata[BIT_STATUS])
      begin
        next_st.status = 1'b0; // [R04]
      end
    end

    // timeout response; set beats a same-cycle clear of the status flag
    if (timeout_hit)
    begin
      next_st.status = 1'b1; // [R03]
      if (st.irq_sel)
      begin
        next_st.wdt_irq = 1'b1; // [R09] [R02]
      end
      else
      begin
        next_st.wdt_reset = 1'b1; // [R06]
        next_st.enable    = 1'b0; // [R10]
        next_st.count     = '0;
      end
    end

    if (i_supply_monitor_irq)
    begin
      next_st.enable = 1'b0; // [R10]
      next_st.count  = '0;
    end

    next_st.rdata = '0;
    next_st.rdata[BIT_PRESCALE_LO +: PRESCALE_W] = next_st.prescale;
    next_st.rdata[BIT_IRQ_SELECT] = next_st.irq_sel;
    next_st.rdata[BIT_STATUS]     = next_st.status;
    next_st.rdata[BIT_ENABLE]     = next_st.enable;
    next_st.rdata[BIT_WRITE_EN]   = next_st.write_en;
  end

  // hardware reset clears everything but the priority flag, which it sets, status included [R04] [R10]
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      st.prot      <= PROT_IDLE;
      st.prescale  <= RESET_PRESCALE;
      st.irq_sel   <= RESET_IRQ_SEL;
      st.status    <= RESET_STATUS;
      st.enable    <= RESET_ENABLE;
      st.write_en  <= 1'b0;
      st.count     <= '0;
      st.wdt_reset <= 1'b0;
      st.wdt_irq   <= 1'b0;
      st.prio_high <= 1'b1;
      st.rdata     <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_sfr_rdata         = st.rdata;
  assign o_wdt_reset         = st.wdt_reset;
  assign o_wdt_irq           = st.wdt_irq;
  assign o_wdt_irq_prio_high = st.prio_high;

  a_status_on_timeout: assert property ( // [R03]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    timeout_hit |=> st.status && o_sfr_rdata[BIT_STATUS])
    else $error("status flag not set after timeout");

  a_status_sticky: assert property ( // [R04]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    st.status && !(write_ok && !i_sfr_wdata[BIT_STATUS]) |=> st.status)
    else $error("status flag lost without zero write");

  a_reset_response: assert property ( // [R06]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    timeout_hit && !st.irq_sel |=> o_wdt_reset && !st.enable ##1 !o_wdt_reset)
    else $error("reset response missing or not a single pulse");

  a_irq_response: assert property ( // [R09]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    timeout_hit && st.irq_sel |=> o_wdt_irq && !o_wdt_reset)
    else $error("interrupt response wrong");

  a_irq_priority: assert property ( // [R01]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    o_wdt_irq |-> o_wdt_irq_prio_high)
    else $error("watchdog interrupt not high priority");

  a_psm_disables: assert property ( // [R10]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_supply_monitor_irq |=> !st.enable ##1 !o_wdt_reset && !o_wdt_irq)
    else $error("supply monitor did not stop watchdog");

  a_refresh_clears: assert property ( // [R05]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    write_ok && i_sfr_wdata[BIT_ENABLE] && !i_supply_monitor_irq && !timeout_hit
    |=> st.enable && st.count == '0)
    else $error("enable write did not refresh counter");

  a_unarmed_ignored: assert property ( // [R08]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_sfr_wr && st.prot != PROT_ARMED && !timeout_hit && !i_supply_monitor_irq
    |=> $stable(st.prescale) && $stable(st.irq_sel) && $stable(st.enable))
    else $error("unprotected write changed register");

  a_quiet_timer: assert property ( // [R02]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    !timeout_hit |=> !o_wdt_reset && !o_wdt_irq)
    else $error("response without timeout");

endmodule : watchdog_status_enable_ctrl

// ### verilog/watchdog_ctrl_pkg.sv
// Purpose: shared constants for the watchdog control register block
// Assumes: one 8-bit control register reached by special-function-register writes
// Notes:   reset values chosen so the watchdog starts disabled
package watchdog_ctrl_pkg;

  localparam int unsigned REG_W          = 8;
  // bit positions of watchdog_control
  localparam int unsigned BIT_PRESCALE_LO = 4;
  localparam int unsigned BIT_IRQ_SELECT  = 3;
  localparam int unsigned BIT_STATUS      = 2;
  localparam int unsigned BIT_ENABLE      = 1;
  localparam int unsigned BIT_WRITE_EN    = 0;
  localparam int unsigned PRESCALE_W      = 4;

  // reset values
  localparam logic [3:0] RESET_PRESCALE  = 4'h0;
  localparam logic       RESET_IRQ_SEL   = 1'b0;
  localparam logic       RESET_ENABLE    = 1'b0;
  localparam logic       RESET_STATUS    = 1'b0;

  // largest prescaler step used; higher codes are reserved and clamp to it
  localparam logic [3:0] PRESCALE_MAX    = 4'h9;
  // timeout period of prescaler code 0, in core clock cycles
  localparam int unsigned TICK_CYCLES    = 32;

  typedef enum logic [1:0] {
    PROT_IDLE,
    PROT_ARMING,
    PROT_ARMED
  } prot_state_t;

endpackage : watchdog_ctrl_pkg

// ### tb/core_sfr_model.sv
// Purpose: core side model issuing special-function-register writes
// Assumes: one instruction per clock cycle except slow_instr, which takes two; each closed by a done pulse
// Notes:   data lines toggle while no write is made, so stale values never look valid
`timescale 1ns/1ps
module core_sfr_model
  import watchdog_ctrl_pkg::*;
(
  input  wire logic                                i_clk_sys,
  output logic                                     o_wr,
  output logic      [watchdog_ctrl_pkg::REG_W-1:0] o_wdata,
  output logic                                     o_done
);
  import watchdog_ctrl_pkg::*;

  initial
  begin
    o_wr    = 1'b0;
    o_wdata = 8'h00;
    o_done  = 1'b0;
  end

  task automatic instr(input logic wr, input logic [REG_W-1:0] d);
    @(posedge i_clk_sys);
    o_wr    <= wr;
    o_wdata <= wr ? d : ~o_wdata;
    o_done  <= 1'b1;
  endtask : instr

  // two-cycle instruction: write in the first cycle, done only in the second
  task automatic slow_instr(input logic wr, input logic [REG_W-1:0] d);
    @(posedge i_clk_sys);
    o_wr    <= wr;
    o_wdata <= wr ? d : ~o_wdata;
    o_done  <= 1'b0;
    @(posedge i_clk_sys);
    o_wr    <= 1'b0;
    o_wdata <= ~o_wdata;
    o_done  <= 1'b1;
  endtask : slow_instr

  task automatic prot_write(input logic [REG_W-1:0] d);
    instr(1'b1, 8'h01);
    instr(1'b1, d);
    instr(1'b0, 8'h00);
  endtask : prot_write
endmodule : core_sfr_model

// ### tb/tb.sv
// Purpose: self-checking bench for the watchdog control register
// Assumes: TICKS shortened to 4 so timeouts come within a few cycles
// Notes:   pulse counters run all along to catch stray reset or interrupt
`timescale 1ns/1ps
module tb;
  import watchdog_ctrl_pkg::*;
  logic             clk, rst_n, wr, done, supply_monitor, w_rst, w_irq, prio;
  logic [REG_W-1:0] wdata, rdata;
  int               num_errors, num_checks, irqs, rsts, n;

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  core_sfr_model u_core (.i_clk_sys(clk), .o_wr(wr), .o_wdata(wdata), .o_done(done));

  watchdog_status_enable_ctrl #(.TICKS(4)) u_dut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
    .i_instr_done(done), .i_supply_monitor_irq(supply_monitor), .o_sfr_rdata(rdata),
    .o_wdt_reset(w_rst), .o_wdt_irq(w_irq), .o_wdt_irq_prio_high(prio));

  always @(posedge clk)
  begin
    irqs <= irqs + int'(w_irq === 1'b1);
    rsts <= rsts + int'(w_rst === 1'b1);
  end

  task automatic chk(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic wait_out(input bit want_irq);
    for (n = 1; n <= 300; n++)
    begin
      @(posedge clk);
      #1;
      if ((want_irq ? w_irq : w_rst) === 1'b1)
        return;
    end
    num_errors++;
    $display("Error %0t: watchdog output never came", $time);
    stop_test();
  endtask : wait_out

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  initial
  begin
    {num_errors, num_checks, irqs, rsts} = '0;
    rst_n = 1'b0;
    supply_monitor   = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk(rdata, 8'h00);
    chk({7'h0, prio}, 8'h01);
    u_core.instr(1'b1, 8'h02);
    u_core.instr(1'b1, 8'h01);
    u_core.instr(1'b0, 8'h00);
    u_core.instr(1'b1, 8'h02);
    u_core.instr(1'b0, 8'h00);
    settle();
    chk(rdata, 8'h00);
    $display("refused writes done");
    // arming instruction spans two cycles before its done pulse
    u_core.slow_instr(1'b1, 8'h01);
    u_core.instr(1'b1, 8'h30);
    u_core.instr(1'b0, 8'h00);
    settle();
    chk(rdata, 8'h30);
    $display("slow arming done");
    u_core.prot_write(8'h0a);
    wait_out(1'b1);
    chk(8'(n), 8'h04);
    settle();
    chk(rdata, 8'h0e);
    chk(8'(rsts), 8'h00);
    $display("interrupt timer done");
    u_core.prot_write(8'h2a);
    // let the pulse counter settle before taking the baseline
    #1;
    n = irqs;
    repeat (6) u_core.prot_write(8'h2a);
    settle();
    chk(8'(irqs - n), 8'h00);
    chk(rdata, 8'h2a);
    $display("refresh done");
    u_core.prot_write(8'h02);
    wait_out(1'b0);
    chk(8'(n), 8'h04);
    settle();
    chk(rdata, 8'h04);
    // longer period so the supply monitor, not a timeout, stops the watchdog
    u_core.prot_write(8'h26);
    settle();
    chk(rdata, 8'h26);
    @(posedge clk) supply_monitor <= 1'b1;
    @(posedge clk) supply_monitor <= 1'b0;
    n = rsts;
    repeat (40) @(posedge clk);
    #1;
    chk(rdata, 8'h24);
    chk(8'(rsts - n), 8'h00);
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    settle();
    chk(rdata, 8'h00);
    $display("reset and supply monitor done");
    stop_test();
  end
endmodule : tb
